// File: rtl/rf_cmd_map.svh
`ifndef RF_CMD_MAP_SVH
`define RF_CMD_MAP_SVH
`define CMD_IDENTIFY       8'h00
`define CMD_READ           8'h06
`define CMD_WRITE          8'h08
`define RSP_IDENTIFY       8'h01
`define RSP_READ           8'h07
`define RSP_WRITE          8'h09
`define SYS_ALL            16'hFFFF
`define SYS_WILDCARD       16'hAAFF
`define REQC_NONE          8'h00
`define REQC_SYSCODE       8'h01
`define REQC_PROTOCOL      8'h02
`define PROTO_CAPS         16'h0083
`define RTD_FIXED_ONES     8'hFF
`define RTD_FIXED_ZERO     8'h00
`define ST_OK              8'h00
`define ST_ERR             8'hFF
`define ST2_NO_HOST        8'h50
`define ST2_HOST_ERR       8'h51
`define ST2_SVC_COUNT      8'hA1
`define ST2_BLK_COUNT      8'hA2
`define ST2_SVC_MISMATCH   8'hA3
`define ST2_BLK_SPEC       8'hA5
`define ST2_SELF_DIAG      8'h60
`define ID_LEN             5'h08
`define FIELD_HI           8'hFF
`endif

// File: rtl/rf_cmd_pkg.sv
package rf_cmd_pkg;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } byte_beat_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [15:0] sys_code;
    logic [7:0] req_code;
    logic [7:0] timeslot;
    logic       tunnel;
    logic       svc_count_bad;
    logic       blk_count_bad;
    logic       svc_mismatch;
    logic       access_bad;
    logic       mode_reserved;
    logic       blk_out_of_range;
    logic       write_read_only;
    logic       plain_to_secure;
    logic       host_timeout;
    logic       host_error;
  } cmd_req_t;

  typedef struct packed {
    logic [15:0] sys_code;
    logic [63:0] card_identifier;
    logic [7:0]  rt_read;
    logic [7:0]  rt_write;
  } tag_cfg_t;

  typedef enum logic [1:0] {
    MATCH_NONE,
    MATCH_ANSWER
  } match_t;
endpackage

// File: rtl/sys_code_match.sv
`timescale 1ns/1ps
`include "rf_cmd_map.svh"
module sys_code_match
  import rf_cmd_pkg::*;
(
  input  wire logic [15:0] i_req_code,
  input  wire logic [15:0] i_own_code,
  output logic             o_match
);
  // identify accepts all, wildcard or own code
  assign o_match = (i_req_code == `SYS_ALL) ||
                   (i_req_code == `SYS_WILDCARD) ||
                   (i_req_code == i_own_code);
endmodule

// File: rtl/rf_command_status_responder.sv
`timescale 1ns/1ps
`include "rf_cmd_map.svh"
// Summary of operation
// - normal completion returns both status bytes as 00
// - tunnel transfer without host answer returns FF 50
// - tunnel transfer answered with host error returns FF 51
// - service file count out of range returns FF A1
// - block count out of range returns FF A2
// - differing service entries return FF A3
// - bad access mode, reserved mode or block beyond memory: FF A5
// - write to read-only or plaintext to secure area: FF 60
// - code 00 is the identify request
// - code 06 is read, memory or host in tunnel mode
// - code 08 is write, memory or host in tunnel mode
// - request code 01 or 02 honoured, anything else means 00
// - timeslot byte ignored, single slot assumed
// - identify reply: code 01, identifier, time descriptor
// - request code 01 appends own system code
// - request code 02 appends 0083
// - descriptor D0 D1 D7 all ones, D2-D4 zero, D5 D6 configured
// - identify reply always sent in first slot
// - failed read reply omits block count and block data
module rf_command_status_responder
  import rf_cmd_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire cmd_req_t   i_cmd,
  input  wire tag_cfg_t   i_cfg,
  input  wire logic [7:0] i_blk_count,
  input  wire logic       i_ready,
  output byte_beat_t      o_beat,
  output logic            o_busy,
  output logic [7:0]      o_status1,
  output logic [7:0]      o_status2,
  output logic            o_is_read,
  output logic            o_is_write,
  output logic            o_tunnel,
  output logic            o_dropped,
  output logic            o_body_en
);
  typedef enum logic [2:0] {
    S_IDLE,
    S_CODE,
    S_ID,
    S_RTD,
    S_REQD,
    S_STAT,
    S_DONE
  } st_e;

  typedef struct packed {
    st_e         st;
    logic [4:0]  idx;
    logic [7:0]  rsp_code;
    logic [1:0]  reqd_kind;
    logic        is_ident;
    logic        is_read;
    logic        is_write;
    logic        tunnel;
    logic [7:0]  s1;
    logic [7:0]  s2;
    logic        dropped;
    logic        body_en;
    logic        busy;
    byte_beat_t  beat;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic   sys_ok;
  logic [7:0] req_eff;
  logic [7:0] rtd_byte;
  logic [7:0] id_byte;
  logic [7:0] err2;
  logic       err;
  logic [15:0] caps;

  // fixed capability word for request code 02
  assign caps = `PROTO_CAPS;

  sys_code_match u_match (
    .i_req_code (i_cmd.sys_code),
    .i_own_code (i_cfg.sys_code),
    .o_match    (sys_ok)
  );

  always_comb begin
    if (i_cmd.req_code == `REQC_SYSCODE ||
        i_cmd.req_code == `REQC_PROTOCOL) begin
      req_eff = i_cmd.req_code;
    end else begin
      req_eff = `REQC_NONE;
    end
  end

  always_comb begin
    err  = 1'b1;
    err2 = `ST_OK;
    if (i_cmd.svc_count_bad) begin
      err2 = `ST2_SVC_COUNT;
    end else if (i_cmd.blk_count_bad) begin
      err2 = `ST2_BLK_COUNT;
    end else if (i_cmd.svc_mismatch) begin
      err2 = `ST2_SVC_MISMATCH;
    end else if (i_cmd.access_bad || i_cmd.mode_reserved ||
                 i_cmd.blk_out_of_range) begin
      err2 = `ST2_BLK_SPEC;
    end else if ((i_cmd.write_read_only &&
                  i_cmd.code == `CMD_WRITE) ||
                 i_cmd.plain_to_secure) begin
      err2 = `ST2_SELF_DIAG;
    end else if (i_cmd.tunnel && i_cmd.host_timeout) begin
      err2 = `ST2_NO_HOST;
    end else if (i_cmd.tunnel && i_cmd.host_error) begin
      err2 = `ST2_HOST_ERR;
    end else begin
      err = 1'b0;
    end
  end

  always_comb begin
    id_byte = i_cfg.card_identifier[63 - 8*s_reg.idx[2:0] -: 8];
  end

  always_comb begin
    case (s_reg.idx[2:0])
      3'h0, 3'h1, 3'h7: rtd_byte = `RTD_FIXED_ONES;
      3'h5: rtd_byte = i_cfg.rt_read;
      3'h6: rtd_byte = i_cfg.rt_write;
      default: rtd_byte = `RTD_FIXED_ZERO;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.dropped = 1'b0;
    if (i_ready) begin
      s_next.beat.valid = 1'b0;
      s_next.beat.last  = 1'b0;
    end
    case (s_reg.st)
      S_IDLE: begin
        s_next.body_en = 1'b0;
        if (i_cmd.valid) begin
          s_next.is_ident = 1'b0;
          s_next.is_read  = 1'b0;
          s_next.is_write = 1'b0;
          s_next.tunnel   = i_cmd.tunnel;
          s_next.idx      = 5'h00;
          s_next.reqd_kind = 2'h0;
          case (i_cmd.code)
            `CMD_IDENTIFY: begin
              if (sys_ok) begin
                s_next.st       = S_CODE;
                s_next.is_ident = 1'b1;
                s_next.rsp_code = `RSP_IDENTIFY;
                s_next.reqd_kind = req_eff[1:0];
              end else begin
                s_next.dropped = 1'b1;
              end
            end
            `CMD_READ: begin
              s_next.st       = S_CODE;
              s_next.is_read  = 1'b1;
              s_next.rsp_code = `RSP_READ;
              s_next.s1       = err ? `ST_ERR : `ST_OK;
              s_next.s2       = err2;
            end
            `CMD_WRITE: begin
              s_next.st       = S_CODE;
              s_next.is_write = 1'b1;
              s_next.rsp_code = `RSP_WRITE;
              s_next.s1       = err ? `ST_ERR : `ST_OK;
              s_next.s2       = err2;
            end
            default: begin
              s_next.dropped = 1'b1;
            end
          endcase
        end
      end
      S_CODE: begin
        if (!s_reg.beat.valid || i_ready) begin
          s_next.beat.valid = 1'b1;
          s_next.beat.data  = s_reg.rsp_code;
          s_next.beat.last  = 1'b0;
          s_next.st         = S_ID;
          s_next.idx        = 5'h00;
        end
      end
      S_ID: begin
        if (!s_reg.beat.valid || i_ready) begin
          s_next.beat.valid = 1'b1;
          s_next.beat.data  = id_byte;
          s_next.beat.last  = 1'b0;
          s_next.idx        = s_reg.idx + 5'h01;
          if (s_reg.idx == `ID_LEN - 5'h01) begin
            s_next.idx = 5'h00;
            s_next.st  = s_reg.is_ident ? S_RTD : S_STAT;
          end
        end
      end
      S_RTD: begin
        if (!s_reg.beat.valid || i_ready) begin
          s_next.beat.valid = 1'b1;
          s_next.beat.data  = rtd_byte;
          s_next.idx        = s_reg.idx + 5'h01;
          s_next.beat.last  = 1'b0;
          if (s_reg.idx == `ID_LEN - 5'h01) begin
            s_next.idx = 5'h00;
            if (s_reg.reqd_kind == 2'h0) begin
              s_next.beat.last = 1'b1;
              s_next.st        = S_DONE;
            end else begin
              s_next.st = S_REQD;
            end
          end
        end
      end
      S_REQD: begin
        if (!s_reg.beat.valid || i_ready) begin
          s_next.beat.valid = 1'b1;
          s_next.idx        = s_reg.idx + 5'h01;
          s_next.beat.last  = (s_reg.idx == 5'h01);
          if (s_reg.reqd_kind == 2'h1) begin
            s_next.beat.data = (s_reg.idx == 5'h00) ?
              i_cfg.sys_code[15:8] : i_cfg.sys_code[7:0];
          end else begin
            s_next.beat.data = (s_reg.idx == 5'h00) ?
              caps[15:8] : caps[7:0];
          end
          if (s_reg.idx == 5'h01) begin
            s_next.st = S_DONE;
          end
        end
      end
      S_STAT: begin
        if (!s_reg.beat.valid || i_ready) begin
          s_next.beat.valid = 1'b1;
          s_next.idx        = s_reg.idx + 5'h01;
          if (s_reg.idx == 5'h00) begin
            s_next.beat.data = s_reg.s1;
            s_next.beat.last = 1'b0;
          end else begin
            s_next.beat.data = s_reg.s2;
            if (s_reg.is_read && s_reg.s1 == `ST_OK) begin
              s_next.beat.last = 1'b0;
              s_next.st        = S_DONE;
              s_next.body_en   = 1'b1;
            end else begin
              s_next.beat.last = 1'b1;
              s_next.st        = S_DONE;
            end
          end
        end
      end
      S_DONE: begin
        if (!s_reg.beat.valid || i_ready) begin
          if (s_reg.body_en && s_reg.idx != 5'h1F) begin
            s_next.beat.valid = 1'b1;
            s_next.beat.data  = i_blk_count;
            s_next.beat.last  = 1'b0;
            s_next.idx        = 5'h1F;
          end else begin
            s_next.st = S_IDLE;
          end
        end
      end
      default: begin
        s_next.st = S_IDLE;
      end
    endcase
    // busy registered so the output comes from a flop
    s_next.busy = (s_next.st != S_IDLE);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_reg.st        <= S_IDLE;
      s_reg.idx       <= 5'h00;
      s_reg.rsp_code  <= 8'h00;
      s_reg.reqd_kind <= 2'h0;
      s_reg.is_ident  <= 1'b0;
      s_reg.is_read   <= 1'b0;
      s_reg.is_write  <= 1'b0;
      s_reg.tunnel    <= 1'b0;
      s_reg.s1        <= `ST_OK;
      s_reg.s2        <= `ST_OK;
      s_reg.dropped   <= 1'b0;
      s_reg.body_en   <= 1'b0;
      s_reg.busy      <= 1'b0;
      s_reg.beat      <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_beat     = s_reg.beat;
  assign o_busy     = s_reg.busy;
  assign o_status1  = s_reg.s1;
  assign o_status2  = s_reg.s2;
  assign o_is_read  = s_reg.is_read;
  assign o_is_write = s_reg.is_write;
  assign o_tunnel   = s_reg.tunnel;
  assign o_dropped  = s_reg.dropped;
  assign o_body_en  = s_reg.body_en;
endmodule

// File: test/rf_command_status_responder_assertions.sv
`timescale 1ns/1ps
module rf_responder_checker
  import rf_cmd_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire cmd_req_t   i_cmd,
  input  wire tag_cfg_t   i_cfg,
  input  wire logic [7:0] i_blk_count,
  input  wire logic       i_ready,
  input  wire byte_beat_t o_beat,
  input  wire logic       o_busy,
  input  wire logic [7:0] o_status1,
  input  wire logic [7:0] o_status2,
  input  wire logic       o_is_read,
  input  wire logic       o_is_write,
  input  wire logic       o_tunnel,
  input  wire logic       o_dropped,
  input  wire logic       o_body_en
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic take;
  logic hit;
  assign take = i_cmd.valid && !o_busy;
  assign hit  = i_cmd.sys_code == 16'hFFFF || i_cmd.sys_code == 16'hAAFF ||
                i_cmd.sys_code == i_cfg.sys_code;
  property p_drop_code;
    take && !(i_cmd.code inside {8'h00, 8'h06, 8'h08}) |=> o_dropped;
  endproperty
  a_drop_code: assert property (p_drop_code)
    else $error("unknown code not dropped");
  property p_drop_sys;
    take && i_cmd.code == 8'h00 && !hit |=> o_dropped;
  endproperty
  a_drop_sys: assert property (p_drop_sys)
    else $error("foreign identify not dropped");
  property p_ident;
    take && i_cmd.code == 8'h00 && hit |->
      ##[1:3] (o_beat.valid && o_beat.data == 8'h01);
  endproperty
  a_ident: assert property (p_ident)
    else $error("identify reply code missing");
  property p_hold;
    o_beat.valid && !i_ready |=> $stable(o_beat);
  endproperty
  a_hold: assert property (p_hold)
    else $error("byte changed while stalled");
  property p_read;
    take && i_cmd.code == 8'h06 |-> ##[1:3] (o_is_read && !o_is_write);
  endproperty
  a_read: assert property (p_read)
    else $error("read not decoded");
  property p_write;
    take && i_cmd.code == 8'h08 |-> ##[1:3] (o_is_write && !o_is_read);
  endproperty
  a_write: assert property (p_write)
    else $error("write not decoded");
  property p_ok;
    take && i_cmd.code == 8'h08 && i_cmd[9:0] == 10'h000 |->
      ##[1:6] (o_status1 == 8'h00 && o_status2 == 8'h00);
  endproperty
  a_ok: assert property (p_ok)
    else $error("normal end status wrong");
  property p_nohost;
    take && i_cmd.code == 8'h06 && i_cmd.tunnel && i_cmd[9:0] == 10'h002
      |-> ##[1:6] ({o_status1, o_status2} == 16'hFF50);
  endproperty
  a_nohost: assert property (p_nohost)
    else $error("host timeout status wrong");
  c_ident: cover property (take && i_cmd.code == 8'h00 && hit);
  c_drop: cover property (o_dropped);
  c_body: cover property (o_body_en);
  c_stall: cover property (o_beat.valid && !i_ready);
endmodule

// File: test/rf_reader_sink.sv
`timescale 1ns/1ps
module rf_reader_sink
  import rf_cmd_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire byte_beat_t i_beat,
  input  wire logic       i_slow,
  output logic            o_ready
);
  logic [8:0] got[$];
  // takes a byte only at an edge with ready high
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_ready <= 1'b0;
    end else begin
      o_ready <= i_slow ? ~o_ready : 1'b1;
      if (i_beat.valid && o_ready) begin
        got.push_back({i_beat.last, i_beat.data});
      end
    end
  end
endmodule

// File: test/tb_rf_command_status_responder.sv
`timescale 1ns/1ps
module tb_rf_command_status_responder
  import rf_cmd_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        slow = 1'b0;
  logic        rdy, busy, is_rd, is_wr, tun, drop, body;
  logic [7:0]  s1, s2;
  logic [7:0]  blk = 8'h00;
  logic [15:0] lf = 16'h44F2;
  logic [9:0]  m;
  cmd_req_t    cmd = '0;
  tag_cfg_t    cfg = '0;
  byte_beat_t  beat;
  logic [8:0]  exp_q[$];
  int          n_fail = 0;
  int          total_checks = 0;
  int          n_drop = 0;
  int          i, n;

  always #2.5 clk = ~clk;
  always @(posedge clk) n_drop <= n_drop + int'(drop === 1'b1);

  rf_command_status_responder dut (
    .i_clk(clk), .i_rst(rst), .i_cmd(cmd), .i_cfg(cfg), .i_blk_count(blk),
    .i_ready(rdy), .o_beat(beat), .o_busy(busy), .o_status1(s1),
    .o_status2(s2), .o_is_read(is_rd), .o_is_write(is_wr), .o_tunnel(tun),
    .o_dropped(drop), .o_body_en(body));
  rf_reader_sink sink (
    .i_clk(clk), .i_rst(rst), .i_beat(beat), .i_slow(slow), .o_ready(rdy));

  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic run(input logic [7:0] code, input logic [7:0] req,
                     input logic [15:0] sys, input logic [9:0] f,
                     input logic t);
    logic [7:0]   e1, e2;
    logic [143:0] v;
    cmd_req_t     c;
    int           k, d0, nb;
    logic         ans, rw;
    e1 = 8'hFF;
    if (f[9]) e2 = 8'hA1;
    else if (f[8]) e2 = 8'hA2;
    else if (f[7]) e2 = 8'hA3;
    else if (|f[6:4]) e2 = 8'hA5;
    else if ((f[3] && code == 8'h08) || f[2]) e2 = 8'h60;
    else if (t && f[1]) e2 = 8'h50;
    else if (t && f[0]) e2 = 8'h51;
    else {e1, e2} = 16'h0000;
    rw = code == 8'h06 || code == 8'h08;
    ans = code == 8'h00 &&
          (sys == 16'hFFFF || sys == 16'hAAFF || sys == cfg.sys_code);
    if (ans) begin
      v = {cfg.card_identifier, 16'hFFFF, 24'h0, cfg.rt_read, cfg.rt_write,
           8'hFF, req == 8'h01 ? cfg.sys_code : 16'h0083};
      nb = (req == 8'h01 || req == 8'h02) ? 18 : 16;
    end else begin
      v = {cfg.card_identifier, e1, e2, blk, 56'h0};
      nb = (e1 == 8'h00 && code == 8'h06) ? 11 : 10;
    end
    exp_q = {};
    if (ans || rw) begin
      exp_q.push_back({1'b0, code + 8'h01});
      for (k = 0; k < nb; k++) begin
        exp_q.push_back({k == nb - 1 && nb != 11, v[143 - 8 * k -: 8]});
      end
    end
    c = '0;
    c.valid = 1'b1;
    c.code = code;
    c.sys_code = sys;
    c.req_code = req;
    c.timeslot = lf[7:0];
    c.tunnel = t;
    c[9:0] = f;
    d0 = n_drop;
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd.valid <= 1'b0;
    repeat (3) @(posedge clk);
    for (k = 0; k < 300 && busy !== 1'b0; k++) @(posedge clk);
    repeat (2) @(posedge clk);
    cmp(busy, 1'b0);
    cmp(16'(n_drop - d0), !(ans || rw));
    cmp(16'(sink.got.size()), 16'(exp_q.size()));
    foreach (exp_q[j]) cmp(sink.got[j], exp_q[j]);
    if (rw) begin
      cmp({s1, s2}, {e1, e2});
      cmp({is_rd, is_wr, tun}, {code == 8'h06, code == 8'h08, t});
    end
    sink.got.delete();
  endtask

  initial begin
    for (i = 0; i < 6; i++) begin
      lf = nx(lf);
      cfg = {cfg[79:0], lf};
    end
    blk = lf[7:0];
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 16; i++) begin
      lf = nx(lf);
      slow <= i[0];
      run(8'h00, i[3:2] == 2'd3 ? {1'b1, lf[6:0]} : {6'h0, i[3:2]},
          i[1:0] == 0 ? 16'hFFFF : i[1:0] == 1 ? 16'hAAFF :
          cfg.sys_code ^ {7'h0, i[0], 8'h0}, 10'h0, 1'b0);
    end
    for (i = 0; i < 44; i++) begin
      lf = nx(lf);
      slow <= lf[3];
      n = (i >> 1) % 11;
      m = n == 0 ? 10'h0 : 10'h200 >> (n - 1);
      run(i[0] ? 8'h08 : 8'h06, 8'h00, 16'h0,
          m | (i > 21 ? lf[9:0] & (m - 10'h1) : 10'h0),
          n > 8 || lf[12]);
    end
    for (i = 0; i < 4; i++) begin
      lf = nx(lf);
      run(lf[7:0] | 8'h10, 8'h00, 16'h0, 10'h0, 1'b0);
    end
    results();
  end

  initial begin
    #200000;
    n_fail++;
    results();
  end
endmodule

bind rf_command_status_responder rf_responder_checker chk (
  .i_clk, .i_rst, .i_cmd, .i_cfg, .i_blk_count, .i_ready, .o_beat, .o_busy,
  .o_status1, .o_status2, .o_is_read, .o_is_write, .o_tunnel, .o_dropped,
  .o_body_en);
